// file: iprb_pkg.sv
// package for the interrupt priority register bank b
// assumes an apb slave with 32-bit data, one register per aligned word
package iprb_pkg;
  // ==========================================================
  // register byte offsets
  localparam logic [7:0] SER_TIM_OFS = 8'h00;
  localparam logic [7:0] CAN_SPI_OFS = 8'h04;
  localparam logic [7:0] DMA3_OFS = 8'h08;
  localparam logic [7:0] DMA4_PP_OFS = 8'h0c;
  localparam logic [7:0] ENC_PWM_OFS = 8'h10;
  localparam logic [7:0] FLT_RTC_OFS = 8'h14;
  // ==========================================================
  // field positions (low bit of each 3-bit field)
  localparam int FLD_HI = 12;
  localparam int FLD_MH = 8;
  localparam int FLD_ML = 4;
  localparam int FLD_LO = 0;
  localparam int PRIO_W = 3;
  // ==========================================================
  // reset and special codes
  localparam logic [2:0] PRIO_RST = 3'h4;
  localparam logic [2:0] PRIO_OFF = 3'h0;
  // implemented-bit masks per register
  localparam logic [15:0] SER_TIM_MSK = 16'h7777;
  localparam logic [15:0] CAN_SPI_MSK = 16'h7777;
  localparam logic [15:0] DMA3_MSK = 16'h0007;
  localparam logic [15:0] DMA4_PP_MSK = 16'h0770;
  localparam logic [15:0] ENC_PWM_MSK = 16'h0770;
  localparam logic [15:0] FLT_RTC_MSK = 16'h7770;
  // reset word: 100 in every implemented field
  localparam logic [15:0] RST_WORD = 16'h4444;
endpackage : iprb_pkg

// file: iprb_reg_if.sv
// interface carrying write strobes from the bus decode to one priority register
// assumes one writer (the top) and one register module
interface iprb_reg_if;
  logic wr;
  logic [15:0] wdata;
  logic [15:0] value;
  modport ctrl (output wr, output wdata, input value);
  modport regs (input wr, input wdata, output value);
endinterface : iprb_reg_if

// file: iprb_prio_reg.sv
// one 16-bit priority register with a mask of implemented bits
// assumes synchronous active-high reset on the shared clock
module iprb_prio_reg #(
  parameter logic [15:0] MASK = 16'hffff
) (
  input wire logic clk,
  input wire logic srst,
  iprb_reg_if.regs bus
);
  logic [15:0] val_q;
  logic [15:0] val_d;
  // ==========================================================
  // storage
  // unimplemented bits never store, so they read zero
  assign val_d = bus.wr ? (bus.wdata & MASK) : val_q;
  always_ff @(posedge clk) begin
    if (srst) begin
      val_q <= iprb_pkg::RST_WORD & MASK;
    end else begin
      val_q <= val_d;
    end
  end
  assign bus.value = val_q;
endmodule : iprb_prio_reg

// file: iprb_top.sv
// interrupt priority register bank b: six apb-mapped priority registers
// assumes apb master on MCLK; arbitration samples the priority outputs
//
// Local design decisions: the APB slave port and the placing of the registers.
module iprb_top #(
  parameter bit HAS_CAN = 1'b1
) (
  input wire logic MCLK,
  input wire logic SRST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  output logic [2:0] SERIAL2_TX_PRIO,
  output logic [2:0] SERIAL2_RX_PRIO,
  output logic [2:0] EXT_IRQ2_PRIO,
  output logic [2:0] TIMER5_PRIO,
  output logic [2:0] CAN_EVENT_PRIO,
  output logic [2:0] CAN_RX_READY_PRIO,
  output logic [2:0] SPI2_EVENT_PRIO,
  output logic [2:0] SPI2_ERROR_PRIO,
  output logic [2:0] DMA_CH3_PRIO,
  output logic [2:0] DMA_CH4_PRIO,
  output logic [2:0] PARALLEL_PORT_PRIO,
  output logic [2:0] ENCODER1_PRIO,
  output logic [2:0] PWM_UNIT1_PRIO,
  output logic [2:0] PWM_FAULT_A_PRIO,
  output logic [2:0] CALENDAR_CLOCK_PRIO,
  output logic [2:0] DMA_CH5_PRIO,
  output logic [15:0] SRC_ENABLED
);
  // ==========================================================
  // helpers
  function automatic logic [2:0] fld(input logic [15:0] w, input int lo);
    fld = w[lo +: iprb_pkg::PRIO_W];
  endfunction : fld

  // ==========================================================
  // apb decode
  iprb_reg_if r_ser ();
  iprb_reg_if r_can ();
  iprb_reg_if r_dma3 ();
  iprb_reg_if r_dma4 ();
  iprb_reg_if r_enc ();
  iprb_reg_if r_flt ();

  logic access;
  logic wr_en;
  logic hit_ser, hit_can, hit_dma3, hit_dma4, hit_enc, hit_flt, hit_any;
  logic [31:0] rdata_d;
  logic [31:0] rdata_q;
  logic err_q;

  // zero-wait slave: every access completes in its first access cycle
  assign access = PSEL & PENABLE;
  assign wr_en = access & PWRITE;
  assign hit_ser = PADDR == iprb_pkg::SER_TIM_OFS;
  assign hit_can = PADDR == iprb_pkg::CAN_SPI_OFS;
  assign hit_dma3 = PADDR == iprb_pkg::DMA3_OFS;
  assign hit_dma4 = PADDR == iprb_pkg::DMA4_PP_OFS;
  assign hit_enc = PADDR == iprb_pkg::ENC_PWM_OFS;
  assign hit_flt = PADDR == iprb_pkg::FLT_RTC_OFS;
  assign hit_any = hit_ser | hit_can | hit_dma3 | hit_dma4 | hit_enc | hit_flt;

  assign r_ser.wr = wr_en & hit_ser;
  assign r_can.wr = wr_en & hit_can;
  assign r_dma3.wr = wr_en & hit_dma3;
  assign r_dma4.wr = wr_en & hit_dma4;
  assign r_enc.wr = wr_en & hit_enc;
  assign r_flt.wr = wr_en & hit_flt;
  assign r_ser.wdata = PWDATA[15:0];
  assign r_can.wdata = PWDATA[15:0];
  assign r_dma3.wdata = PWDATA[15:0];
  assign r_dma4.wdata = PWDATA[15:0];
  assign r_enc.wdata = PWDATA[15:0];
  assign r_flt.wdata = PWDATA[15:0];

  // ==========================================================
  // registers
  iprb_prio_reg #(.MASK(iprb_pkg::SER_TIM_MSK)) u_ser (
    .clk(MCLK),
    .srst(SRST),
    .bus(r_ser)
  );
  iprb_prio_reg #(.MASK(iprb_pkg::CAN_SPI_MSK)) u_can (
    .clk(MCLK),
    .srst(SRST),
    .bus(r_can)
  );
  iprb_prio_reg #(.MASK(iprb_pkg::DMA3_MSK)) u_dma3 (
    .clk(MCLK),
    .srst(SRST),
    .bus(r_dma3)
  );
  iprb_prio_reg #(.MASK(iprb_pkg::DMA4_PP_MSK)) u_dma4 (
    .clk(MCLK),
    .srst(SRST),
    .bus(r_dma4)
  );
  iprb_prio_reg #(.MASK(iprb_pkg::ENC_PWM_MSK)) u_enc (
    .clk(MCLK),
    .srst(SRST),
    .bus(r_enc)
  );
  iprb_prio_reg #(.MASK(iprb_pkg::FLT_RTC_MSK)) u_flt (
    .clk(MCLK),
    .srst(SRST),
    .bus(r_flt)
  );

  // ==========================================================
  // read path
  // read data is combinational from the registers, flopped at the end of the setup cycle
  assign rdata_d = hit_ser ? {16'h0000, r_ser.value} :
                   hit_can ? {16'h0000, r_can.value} :
                   hit_dma3 ? {16'h0000, r_dma3.value} :
                   hit_dma4 ? {16'h0000, r_dma4.value} :
                   hit_enc ? {16'h0000, r_enc.value} :
                   hit_flt ? {16'h0000, r_flt.value} : 32'h00000000;

  always_ff @(posedge MCLK) begin
    if (SRST) begin
      rdata_q <= 32'h00000000;
      err_q <= 1'b0;
    end else begin
      if (PSEL & ~PENABLE) begin
        rdata_q <= rdata_d;
        err_q <= ~hit_any;
      end
    end
  end

  // setup captures the data so it stands through the access cycle
  assign PRDATA = rdata_q;
  assign PREADY = 1'b1;
  assign PSLVERR = access & err_q;

  // ==========================================================
  // priority outputs to arbitration
  logic can_on;
  assign can_on = HAS_CAN;

  assign SERIAL2_TX_PRIO = fld(r_ser.value, iprb_pkg::FLD_HI);
  assign SERIAL2_RX_PRIO = fld(r_ser.value, iprb_pkg::FLD_MH);
  assign EXT_IRQ2_PRIO = fld(r_ser.value, iprb_pkg::FLD_ML);
  assign TIMER5_PRIO = fld(r_ser.value, iprb_pkg::FLD_LO);
  // without the can controller the sources read as disabled to arbitration
  assign CAN_EVENT_PRIO = can_on ? fld(r_can.value, iprb_pkg::FLD_HI)
                                 : iprb_pkg::PRIO_OFF;
  assign CAN_RX_READY_PRIO = can_on ? fld(r_can.value, iprb_pkg::FLD_MH)
                                    : iprb_pkg::PRIO_OFF;
  assign SPI2_EVENT_PRIO = fld(r_can.value, iprb_pkg::FLD_ML);
  assign SPI2_ERROR_PRIO = fld(r_can.value, iprb_pkg::FLD_LO);
  assign DMA_CH3_PRIO = fld(r_dma3.value, iprb_pkg::FLD_LO);
  assign DMA_CH4_PRIO = fld(r_dma4.value, iprb_pkg::FLD_MH);
  assign PARALLEL_PORT_PRIO = fld(r_dma4.value, iprb_pkg::FLD_ML);
  assign ENCODER1_PRIO = fld(r_enc.value, iprb_pkg::FLD_MH);
  assign PWM_UNIT1_PRIO = fld(r_enc.value, iprb_pkg::FLD_ML);
  assign PWM_FAULT_A_PRIO = fld(r_flt.value, iprb_pkg::FLD_HI);
  assign CALENDAR_CLOCK_PRIO = fld(r_flt.value, iprb_pkg::FLD_MH);
  assign DMA_CH5_PRIO = fld(r_flt.value, iprb_pkg::FLD_ML);

  // a zero field keeps its source out of arbitration
  assign SRC_ENABLED = {
    SERIAL2_TX_PRIO != iprb_pkg::PRIO_OFF,
    SERIAL2_RX_PRIO != iprb_pkg::PRIO_OFF,
    EXT_IRQ2_PRIO != iprb_pkg::PRIO_OFF,
    TIMER5_PRIO != iprb_pkg::PRIO_OFF,
    CAN_EVENT_PRIO != iprb_pkg::PRIO_OFF,
    CAN_RX_READY_PRIO != iprb_pkg::PRIO_OFF,
    SPI2_EVENT_PRIO != iprb_pkg::PRIO_OFF,
    SPI2_ERROR_PRIO != iprb_pkg::PRIO_OFF,
    DMA_CH3_PRIO != iprb_pkg::PRIO_OFF,
    DMA_CH4_PRIO != iprb_pkg::PRIO_OFF,
    PARALLEL_PORT_PRIO != iprb_pkg::PRIO_OFF,
    ENCODER1_PRIO != iprb_pkg::PRIO_OFF,
    PWM_UNIT1_PRIO != iprb_pkg::PRIO_OFF,
    PWM_FAULT_A_PRIO != iprb_pkg::PRIO_OFF,
    CALENDAR_CLOCK_PRIO != iprb_pkg::PRIO_OFF,
    DMA_CH5_PRIO != iprb_pkg::PRIO_OFF
  };
endmodule : iprb_top

// file: iprb_asserts.sv
// checker for the priority register bank, bound to the top
// assumes apb traffic on MCLK and synchronous reset SRST
module iprb_asserts (
  input wire logic MCLK,
  input wire logic SRST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [31:0] PRDATA,
  input wire logic PSLVERR,
  input wire logic [2:0] SERIAL2_TX_PRIO,
  input wire logic [2:0] TIMER5_PRIO,
  input wire logic [2:0] DMA_CH3_PRIO,
  input wire logic [15:0] SRC_ENABLED
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================
  // helpers
  default clocking @(posedge MCLK); endclocking
  default disable iff (SRST);
  logic [31:0] wd_q;
  wire acc = PSEL && PENABLE;
  always_ff @(posedge MCLK) begin
    wd_q <= PWDATA;
  end
  // ==========================================================
  // properties
  a_reset_level: assert property ($fell(SRST) |-> TIMER5_PRIO == 3'h4 && DMA_CH3_PRIO == 3'h4)
    else $error("field not at level 4 after reset");
  a_enable_flag: assert property (SRC_ENABLED[12] == (TIMER5_PRIO != 3'h0))
    else $error("enable flag disagrees with field");
  a_write_first: assert property (acc && PWRITE && PADDR == 8'h00 |=>
    TIMER5_PRIO == wd_q[2:0] && SERIAL2_TX_PRIO == wd_q[14:12]) else $error("write not applied");
  a_write_dma3: assert property (acc && PWRITE && PADDR == 8'h08 |=> DMA_CH3_PRIO == wd_q[2:0])
    else $error("dma3 write not applied");
  a_hold_value: assert property (!(acc && PWRITE) |=> $stable(TIMER5_PRIO) && $stable(DMA_CH3_PRIO))
    else $error("field changed without write");
  a_read_zero: assert property (acc && !PWRITE |-> PRDATA[31:15] == 17'h0 && PRDATA[11] == 1'b0
    && PRDATA[7] == 1'b0 && PRDATA[3] == 1'b0) else $error("unimplemented bit reads one");
  a_read_back: assert property (acc && !PWRITE && PADDR == 8'h08 |-> PRDATA == {29'h0, DMA_CH3_PRIO})
    else $error("dma3 readback wrong");
  a_unmapped_err: assert property (acc && PADDR > 8'h14 |-> PSLVERR && (PWRITE || PRDATA == 32'h0))
    else $error("unmapped access not refused");
endmodule : iprb_asserts

bind iprb_top iprb_asserts i_iprb_asserts (.*);

// file: iprb_arb_model.sv
// far-side model: arbitration picking the highest active level
// assumes one 3-bit level per source, zero meaning off
module iprb_arb_model (
  input wire logic [2:0] lvl [16],
  output logic [2:0] top_lvl
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================
  // arbitration: zero never beats anything, so off sources drop out
  always_comb begin
    top_lvl = 3'h0;
    for (int k = 0; k < 16; k++) begin
      if (lvl[k] > top_lvl) top_lvl = lvl[k];
    end
  end
endmodule : iprb_arb_model

// file: test_iprb_top.sv
// self-checking bench for the priority register bank
// assumes apb master here, arbitration model on the priority outputs
module test_iprb_top;
  timeunit 1ns;
  timeprecision 1ps;
  `define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin error_cnt++; \
    $display("unexpected at %0t: %h vs %h", $time, a, b); end end
  logic mclk, srst, psel, penable, pwrite, pready, pslverr, e;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [2:0] p [16];
  logic [2:0] top_lvl;
  logic [2:0] ce, cr;
  logic [15:0] src_en, d;
  logic [15:0] m [6];
  int error_cnt = 0, cmp_count = 0, cyc = 0, i;
  localparam logic [15:0] MSK [6] = '{16'h7777, 16'h7777, 16'h0007, 16'h0770, 16'h0770, 16'h7770};
  localparam int SR [16] = '{0, 0, 0, 0, 1, 1, 1, 1, 2, 3, 3, 4, 4, 5, 5, 5};
  localparam int SB [16] = '{12, 8, 4, 0, 12, 8, 4, 0, 0, 8, 4, 8, 4, 12, 8, 4};
  // ==========================================================
  // design and far side; no can unit, so its sources must stay off
  // a second copy with the can unit must pass the can fields through
  iprb_top #(.HAS_CAN(1'b0)) i_iprb_top (.MCLK(mclk), .SRST(srst), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr), .SERIAL2_TX_PRIO(p[0]), .SERIAL2_RX_PRIO(p[1]), .EXT_IRQ2_PRIO(p[2]),
    .TIMER5_PRIO(p[3]), .CAN_EVENT_PRIO(p[4]), .CAN_RX_READY_PRIO(p[5]), .SPI2_EVENT_PRIO(p[6]),
    .SPI2_ERROR_PRIO(p[7]), .DMA_CH3_PRIO(p[8]), .DMA_CH4_PRIO(p[9]), .PARALLEL_PORT_PRIO(p[10]),
    .ENCODER1_PRIO(p[11]), .PWM_UNIT1_PRIO(p[12]), .PWM_FAULT_A_PRIO(p[13]),
    .CALENDAR_CLOCK_PRIO(p[14]), .DMA_CH5_PRIO(p[15]), .SRC_ENABLED(src_en));
  iprb_top #(.HAS_CAN(1'b1)) i_iprb_top_can (.MCLK(mclk), .SRST(srst), .PSEL(psel),
    .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(), .PREADY(),
    .PSLVERR(), .SERIAL2_TX_PRIO(), .SERIAL2_RX_PRIO(), .EXT_IRQ2_PRIO(), .TIMER5_PRIO(),
    .CAN_EVENT_PRIO(ce), .CAN_RX_READY_PRIO(cr), .SPI2_EVENT_PRIO(), .SPI2_ERROR_PRIO(),
    .DMA_CH3_PRIO(), .DMA_CH4_PRIO(), .PARALLEL_PORT_PRIO(), .ENCODER1_PRIO(),
    .PWM_UNIT1_PRIO(), .PWM_FAULT_A_PRIO(), .CALENDAR_CLOCK_PRIO(), .DMA_CH5_PRIO(),
    .SRC_ENABLED());
  iprb_arb_model i_iprb_arb_model (.lvl(p), .top_lvl(top_lvl));
  // ==========================================================
  // expectations and bus tasks
  function automatic logic [2:0] ef(int j);
    ef = (j == 4 || j == 5) ? 3'h0 : m[SR[j]][SB[j] +: 3];
  endfunction : ef
  task automatic finish_test();
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : finish_test
  task automatic xfer(input logic w, input int a, input logic [31:0] wd);
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= 8'(a * 4);
    pwdata <= wd;
    @(posedge mclk);
    penable <= 1'b1;
    @(posedge mclk);
    while (pready !== 1'b1) @(posedge mclk);
    rd = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : xfer
  task automatic check_all();
    logic [2:0] mx;
    mx = 3'h0;
    for (int r = 0; r < 6; r++) begin
      xfer(1'b0, r, 32'h0);
      `CHK({e, rd}, {1'b0, 16'h0, m[r]})
    end
    for (int j = 0; j < 16; j++) begin
      `CHK(p[j], ef(j))
      `CHK(src_en[15 - j], ef(j) != 3'h0)
      if (ef(j) > mx) mx = ef(j);
    end
    `CHK(top_lvl, mx)
    `CHK({ce, cr}, {m[1][14:12], m[1][10:8]})
  endtask : check_all
  // ==========================================================
  // clock, watchdog and main sequence
  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      error_cnt++;
      finish_test();
    end
  end
  initial begin
    {srst, psel, penable, pwrite, paddr, pwdata} = {1'b1, 43'h0};
    void'($urandom(32'h4220));
    for (int r = 0; r < 6; r++) m[r] = 16'h4444 & MSK[r];
    repeat (10) @(posedge mclk);
    srst <= 1'b0;
    check_all();
    xfer(1'b0, 6, 32'h0);
    `CHK({e, rd}, {1'b1, 32'h0})
    xfer(1'b1, 7, 32'hffffffff);
    `CHK(e, 1'b1)
    for (int n = 0; n < 60; n++) begin
      i = (n < 18) ? n % 6 : $urandom_range(5);
      d = (n < 6) ? 16'hffff : ((n < 12) ? 16'h3333 : ((n < 18) ? 16'h0000 : 16'($urandom)));
      xfer(1'b1, i, {16'($urandom), d});
      m[i] = d & MSK[i];
      check_all();
    end
    // reset in mid-run must bring every field back to level 4
    srst <= 1'b1;
    repeat (2) @(posedge mclk);
    srst <= 1'b0;
    for (int r = 0; r < 6; r++) m[r] = 16'h4444 & MSK[r];
    check_all();
    finish_test();
  end
endmodule : test_iprb_top
